// [rtl/supply_monitor_consts.vh]
// constants for the supply voltage monitor block
// assumes a 50 MHz sys_clk and an Avalon-MM slave with 32-bit data
`ifndef SUPPLY_MONITOR_CONSTS_VH
`define SUPPLY_MONITOR_CONSTS_VH

// register word addresses (byte address = 4 * index)
`define ADDR_W 4
`define OFS_STATUS_CONTROL 4'h0
`define OFS_CONFIG 4'h1
`define OFS_EVENT_STATUS 4'h2
`define OFS_EVENT_MASK 4'h3

// status/control bit positions
`define BIT_FLAG 7
`define BIT_TRIP_SEL 0

// config bit positions
`define BIT_POWER 0
`define BIT_RST_EN 1

// event bit positions
`define EV_RESET 0
`define EV_FLAG_RISE 1
`define EV_W 2

// reset values
`define RST_POWER 1'b1
`define RST_RST_EN 1'b1
`define RST_TRIP_SEL 1'b0

// filter counts in reference clock cycles
`define CNT_W 6
`define RESET_FILTER_CYCLES 6'h09
`define FLAG_FILTER_CYCLES 6'h24
`define RECOVER_CYCLES 6'h01

`endif

// [rtl/low_filter.v]
// saturating run-length filter on a low-supply indication
// assumes the indication is synchronous to sys_clk
`timescale 1ns/1ps
module low_filter #(
  parameter [5:0] LIMIT = 6'h09
) (
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire below,
  output wire reached
);
  reg [5:0] count;

  // restart whenever the supply rises or the filter is idle
  always @(posedge sys_clk) begin
    if (srst || !run || !below) begin
      count <= 6'h00;
    end else if (count != LIMIT) begin
      count <= count + 6'h01;
    end
  end

  // saturation at the limit marks the run length met
  assign reached = run && below && (count == LIMIT);
endmodule // low_filter

// [rtl/sticky_events.v]
// sticky event bits with write-one-to-clear and a mask
// assumes one-cycle event pulses and one-cycle clear strobes
`timescale 1ns/1ps
module sticky_events #(
  parameter W = 2
) (
  input wire sys_clk,
  input wire srst,
  input wire [W-1:0] events,
  input wire clear_strobe,
  input wire [W-1:0] clear_bits,
  input wire [W-1:0] mask,
  output reg [W-1:0] status,
  output wire irq
);
  // a set in the same cycle as a clear wins
  always @(posedge sys_clk) begin
    if (srst) begin
      status <= {W{1'b0}};
    end else begin
      status <= (status & ~(clear_strobe ? clear_bits : {W{1'b0}}))
        | events;
    end
  end

  assign irq = |(status & mask);
endmodule // sticky_events

// [rtl/supply_voltage_monitor.v]
// digital side of the supply voltage monitor: filters, reset, flag
// assumes comparator levels synchronous to sys_clk, Avalon-MM master
//
// Notes on behaviour
// - monitor comes out of reset enabled, no software setup needed
// - comparison active only while the power bit is set
// - reset after nine or more consecutive cycles at or below trip
// - reset held until above trip plus hysteresis for one cycle
// - undervoltage flag set through its own filter, not straight from the comparator
// - active low reset pin driven low during monitor reset
// - tolerance select resets to zero, ten percent; one selects five
// - flag read-only, cleared by reset, set after 32 to 40 cycles low
// - flag zero above recovery, held in hysteresis band, one past 40
// - tolerance change with both bits set resets if below new trip
// - monitor raises no interrupt request of its own; event_irq is raised here for unmasked events
// - stays active in wait mode; its reset ends wait
// - stays active in stop mode; its reset ends stop
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`include "supply_monitor_consts.vh"
`timescale 1ns/1ps
module supply_voltage_monitor (
  input wire sys_clk,
  input wire srst,
  // comparator levels for both tolerance settings
  input wire below_trip_5pct,
  input wire above_recovery_5pct,
  input wire below_trip_10pct,
  input wire above_recovery_10pct,
  // low power modes of the core
  input wire wait_mode,
  input wire stop_mode,
  // Avalon-MM slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg avs_response_error,
  // outputs
  output reg monitor_reset,
  output wire reset_pin_n_out,
  output wire reset_pin_oe_n,
  output wire wake_request,
  output reg undervoltage_flag,
  output wire event_irq
);
  reg monitor_power_bit;
  reg monitor_reset_enable_bit;
  reg trip_tolerance_select;
  reg [`EV_W-1:0] event_mask;
  reg ack_phase;
  reg prev_flag;
  wire below_trip;
  wire above_recovery;
  wire reset_filter_hit;
  wire flag_filter_hit;
  wire reset_armed;
  wire flag_armed;
  wire bus_req;
  wire wr_take;
  wire rd_take;
  wire [`EV_W-1:0] event_status;
  wire [`EV_W-1:0] events;
  wire reset_rise;
  wire flag_rise;
  wire ev_clear;

  // one wait state: request taken on the second cycle it is seen
  assign bus_req = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_phase;
  assign wr_take = avs_write & ack_phase;
  assign rd_take = avs_read & ack_phase;

  always @(posedge sys_clk) begin
    if (srst) begin
      ack_phase <= 1'b0;
    end else begin
      ack_phase <= bus_req & ~ack_phase;
    end
  end

  // comparator selected by tolerance; new selection acts at once
  assign below_trip = trip_tolerance_select ? below_trip_5pct
    : below_trip_10pct;
  assign above_recovery = trip_tolerance_select ? above_recovery_5pct
    : above_recovery_10pct;

  // power bit gates all comparison, in run, wait and stop alike
  assign reset_armed = monitor_power_bit & monitor_reset_enable_bit;
  assign flag_armed = monitor_power_bit;

  low_filter #(
    .LIMIT(`RESET_FILTER_CYCLES)
  ) u_reset_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(reset_armed),
    .below(below_trip),
    .reached(reset_filter_hit)
  );

  // flag set at 36 cycles, inside the 32 to 40 window
  low_filter #(
    .LIMIT(`FLAG_FILTER_CYCLES)
  ) u_flag_filter (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(flag_armed),
    .below(below_trip),
    .reached(flag_filter_hit)
  );

  // config registers: enabled out of reset, ten percent tolerance
  always @(posedge sys_clk) begin
    if (srst) begin
      monitor_power_bit <= `RST_POWER;
      monitor_reset_enable_bit <= `RST_RST_EN;
      trip_tolerance_select <= `RST_TRIP_SEL;
      event_mask <= {`EV_W{1'b0}};
    end else if (wr_take && avs_byteenable[0]) begin
      case (avs_address)
        `OFS_STATUS_CONTROL: begin
          trip_tolerance_select <= avs_writedata[`BIT_TRIP_SEL];
        end
        `OFS_CONFIG: begin
          monitor_power_bit <= avs_writedata[`BIT_POWER];
          monitor_reset_enable_bit <= avs_writedata[`BIT_RST_EN];
        end
        `OFS_EVENT_MASK: begin
          event_mask <= avs_writedata[`EV_W-1:0];
        end
        default: begin
          event_mask <= event_mask;
        end
      endcase
    end
  end

  // reset: asserted after filter, released after one cycle above
  // recovery; band between trip and recovery keeps it asserted
  always @(posedge sys_clk) begin
    if (srst) begin
      monitor_reset <= 1'b0;
    end else if (reset_filter_hit) begin
      monitor_reset <= 1'b1;
    end else if (monitor_reset && (above_recovery || !reset_armed)) begin
      monitor_reset <= 1'b0;
    end
  end

  // the pin is pulled low while reset stands, released otherwise
  assign reset_pin_n_out = 1'b0;
  assign reset_pin_oe_n = ~monitor_reset;
  // reset also wakes the core from wait or stop
  assign wake_request = monitor_reset & (wait_mode | stop_mode);

  // flag: set by filter, cleared above recovery, held in band
  always @(posedge sys_clk) begin
    if (srst || !monitor_power_bit) begin
      undervoltage_flag <= 1'b0;
    end else if (flag_filter_hit) begin
      undervoltage_flag <= 1'b1;
    end else if (above_recovery) begin
      undervoltage_flag <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (srst) begin
      prev_flag <= 1'b0;
    end else begin
      prev_flag <= undervoltage_flag;
    end
  end

  // status events for software, raised on event_irq when unmasked
  assign reset_rise = reset_filter_hit & ~monitor_reset;
  assign flag_rise = undervoltage_flag & ~prev_flag;
  assign events = {flag_rise, reset_rise};
  assign ev_clear = wr_take & avs_byteenable[0]
    & (avs_address == `OFS_EVENT_STATUS);

  sticky_events #(
    .W(`EV_W)
  ) u_events (
    .sys_clk(sys_clk),
    .srst(srst),
    .events(events),
    .clear_strobe(ev_clear),
    .clear_bits(avs_writedata[`EV_W-1:0]),
    .mask(event_mask),
    .status(event_status),
    .irq(event_irq)
  );

  // read data and error answer registered one edge before the accept edge
  always @(posedge sys_clk) begin
    if (srst) begin
      avs_readdata <= 32'h00000000;
      avs_response_error <= 1'b0;
    end else if (bus_req && !ack_phase) begin
      avs_readdata <= 32'h00000000;
      avs_response_error <= 1'b0;
      case (avs_address)
        `OFS_STATUS_CONTROL: begin
          avs_readdata[`BIT_FLAG] <= undervoltage_flag;
          avs_readdata[`BIT_TRIP_SEL] <= trip_tolerance_select;
        end
        `OFS_CONFIG: begin
          avs_readdata[`BIT_POWER] <= monitor_power_bit;
          avs_readdata[`BIT_RST_EN] <= monitor_reset_enable_bit;
        end
        `OFS_EVENT_STATUS: begin
          avs_readdata[`EV_W-1:0] <= event_status;
        end
        `OFS_EVENT_MASK: begin
          avs_readdata[`EV_W-1:0] <= event_mask;
        end
        default: begin
          avs_response_error <= 1'b1;
        end
      endcase
    end
  end
endmodule // supply_voltage_monitor

// [test/supply_comparator_model.sv]
// comparator model: abstract supply level to trip and recovery outputs
// assumes the level changes just after a sys_clk edge
`timescale 1ns/1ps
module supply_comparator_model #(
  parameter [2:0] TRIP5 = 3'h4,
  parameter [2:0] TRIP10 = 3'h2
) (
  input wire [2:0] level,
  output wire below5,
  output wire above5,
  output wire below10,
  output wire above10
);
  // band of one step above each trip, so levels never overlap
  assign below5 = level <= TRIP5;
  assign above5 = level > TRIP5 + 3'h1;
  assign below10 = level <= TRIP10;
  assign above10 = level > TRIP10 + 3'h1;
endmodule // supply_comparator_model

// [test/supply_voltage_monitor_assertions.sv]
// port checker for the supply voltage monitor
// assumes it is bound onto supply_voltage_monitor
`timescale 1ns/1ps
module supply_voltage_monitor_assertions (
  input wire sys_clk,
  input wire srst,
  input wire below_trip_5pct,
  input wire above_recovery_5pct,
  input wire below_trip_10pct,
  input wire above_recovery_10pct,
  input wire wait_mode,
  input wire stop_mode,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire monitor_reset,
  input wire reset_pin_n_out,
  input wire reset_pin_oe_n,
  input wire wake_request,
  input wire undervoltage_flag
);
  reg [5:0] low5 = 6'h00;
  reg [5:0] low10 = 6'h00;
  // saturating run lengths; either trip may be the selected one
  always @(posedge sys_clk) begin
    low5 <= !below_trip_5pct ? 6'h00 : (&low5 ? low5 : low5 + 6'h01);
    low10 <= !below_trip_10pct ? 6'h00 : (&low10 ? low10 : low10 + 6'h01);
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  a_pin_drive:
    assert property (reset_pin_oe_n == !monitor_reset)
    else $error("reset pin enable not tracking reset");
  a_pin_level:
    assert property (!reset_pin_oe_n |-> !reset_pin_n_out)
    else $error("reset pin driven high");
  a_wake_on_reset:
    assert property (wake_request
      == (monitor_reset && (wait_mode || stop_mode)))
    else $error("wake request wrong");
  a_reset_filter:
    assert property ($rose(monitor_reset)
      |-> low5 >= 6'h09 || low10 >= 6'h09)
    else $error("reset before nine low cycles");
  a_flag_filter:
    assert property ($rose(undervoltage_flag)
      |-> low5 >= 6'h20 || low10 >= 6'h20)
    else $error("flag set before 32 low cycles");
  a_reset_release:
    assert property ((above_recovery_5pct && above_recovery_10pct) [*2]
      |-> !monitor_reset) else $error("reset held above recovery");
  a_flag_clear:
    assert property ((above_recovery_5pct && above_recovery_10pct) [*2]
      |-> !undervoltage_flag) else $error("flag set above recovery");
  a_one_wait: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest ##1 !avs_waitrequest) else $error("bad wait state");
endmodule // supply_voltage_monitor_assertions
bind supply_voltage_monitor supply_voltage_monitor_assertions
  supply_voltage_monitor_assertions_i (.*);

// [test/test_supply_voltage_monitor.sv]
// self-checking bench for the supply voltage monitor
// assumes the comparator model and the bound checker are compiled
`include "supply_monitor_consts.vh"
`timescale 1ns/1ps
module test_supply_voltage_monitor;
  reg sys_clk = 1'b0;
  reg srst = 1'b1;
  reg [2:0] level = 3'h7;
  reg wait_mode = 1'b0;
  reg stop_mode = 1'b0;
  reg [3:0] adr = 4'h0;
  reg rd_en = 1'b0;
  reg wr_en = 1'b0;
  reg [31:0] wdata = 32'h0;
  reg [3:0] be_out = 4'hF;
  reg [3:0] be = 4'hF;
  reg [31:0] rng = 32'h00017790;
  reg [31:0] rd;
  reg err;
  reg sel;
  wire [31:0] rdata;
  wire waitreq, rsp_err, mon_rst, pin_n, pin_oe_n, wake, flag, irq;
  wire b5, a5, b10, a10;
  integer n_fail = 0;
  integer checked = 0;
  integer cyc = 0;
  integer i;
  supply_comparator_model supply_comparator_model_i (.level(level),
    .below5(b5), .above5(a5), .below10(b10), .above10(a10));
  supply_voltage_monitor supply_voltage_monitor_i (.sys_clk(sys_clk),
    .srst(srst), .below_trip_5pct(b5), .above_recovery_5pct(a5),
    .below_trip_10pct(b10), .above_recovery_10pct(a10),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .avs_address(adr),
    .avs_read(rd_en), .avs_write(wr_en), .avs_writedata(wdata),
    .avs_byteenable(be_out), .avs_readdata(rdata),
    .avs_waitrequest(waitreq), .avs_response_error(rsp_err),
    .monitor_reset(mon_rst), .reset_pin_n_out(pin_n),
    .reset_pin_oe_n(pin_oe_n), .wake_request(wake),
    .undervoltage_flag(flag), .event_irq(irq));
  initial forever #10 sys_clk = ~sys_clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      end_sim;
    end
  end
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  task check(input [31:0] seen, input [31:0] exp, input [95:0] what);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // one bus access; holds until waitrequest is seen low at an edge
  task bus(input wr, input [3:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      adr <= a;
      wr_en <= wr;
      rd_en <= !wr;
      wdata <= d;
      be_out <= be;
      // answer and data are taken at the edge that sees waitrequest low
      @(posedge sys_clk);
      while (waitreq !== 1'b0) @(posedge sys_clk);
      rd = rdata;
      err = rsp_err;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // bounded wait for the monitor reset to reach a level
  task wait_rst(input v);
    for (i = 0; i < 12 && mon_rst !== v; i = i + 1) wt(1);
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    wt(6);
    srst <= 1'b0;
    bus(0, `OFS_STATUS_CONTROL, 0);
    check(rd, 32'h0, "stat reset");
    bus(0, `OFS_CONFIG, 0);
    check(rd, {`RST_RST_EN, `RST_POWER}, "cfg reset");
    bus(0, 4'h9, 0);
    check(err, 1, "unmapped");
    wt(1); wait_mode <= 1'b1; level <= 3'h0; wt(8); level <= 3'h7;
    wt(4); #1 check(mon_rst, 0, "eight low");
    wt(1); level <= 3'h0; wait_rst(1'b1); #1 check(mon_rst, 1, "rst");
    check(pin_oe_n, 0, "pin oe");
    check(wake, 1, "wake wait");
    wt(1); wait_mode <= 1'b0; stop_mode <= 1'b1; level <= 3'h3;
    wt(5); #1 check(wake, 1, "wake stop");
    check(mon_rst, 1, "band hold");
    wt(1); level <= 3'h7; wait_rst(1'b0); #1 check(mon_rst, 0, "rel");
    stop_mode <= 1'b0;
    bus(0, `OFS_EVENT_STATUS, 0);
    check(rd[`EV_RESET], 1, "ev reset");
    bus(1, `OFS_EVENT_MASK, 32'h1 << `EV_RESET);
    #1 check(irq, 1, "irq on");
    bus(1, `OFS_EVENT_STATUS, 32'h3);
    #1 check(irq, 0, "irq clear");
    bus(1, `OFS_CONFIG, 32'h1);
    bus(1, `OFS_STATUS_CONTROL, 32'h1);
    wt(1); level <= 3'h0; wt(42); #1 check(flag, 1, "flag set");
    check(mon_rst, 0, "polled");
    bus(0, `OFS_STATUS_CONTROL, 0);
    check(rd, 32'h81, "flag read");
    wt(1); level <= 3'h5; wt(10); #1 check(flag, 1, "flag band");
    wt(1); level <= 3'h7; wt(2); #1 check(flag, 0, "flag clr");
    wt(1); level <= 3'h0; wt(30); #1 check(flag, 0, "flag short");
    wt(1); level <= 3'h7;
    bus(1, `OFS_CONFIG, 32'h3);
    bus(1, `OFS_STATUS_CONTROL, 32'h0);
    wt(1); level <= 3'h3; wt(15); #1 check(mon_rst, 0, "ten pct");
    bus(1, `OFS_STATUS_CONTROL, 32'h1);
    wait_rst(1'b1); #1 check(mon_rst, 1, "trip change");
    wt(1); level <= 3'h7; wait_rst(1'b0);
    bus(1, `OFS_CONFIG, 32'h0);
    wt(1); level <= 3'h0; wt(45); #1 check(mon_rst, 0, "off rst");
    check(flag, 0, "off flag");
    wt(1); level <= 3'h7;
    sel = 1'b1;
    // random trip selects with random lane enables
    repeat (8) begin
      rng = xs(rng);
      be = rng[7:4];
      bus(1, `OFS_STATUS_CONTROL, rng);
      sel = be[0] ? rng[0] : sel;
      be = 4'hF;
      bus(0, `OFS_STATUS_CONTROL, 0);
      check(rd, {31'h0, sel}, "sel rand");
    end
    end_sim;
  end
endmodule // test_supply_voltage_monitor
